// ### mpps_map.svh
// constants for the multiphase pulse sequencer: counts, widths, reset values
// assumes a 20 MHz core_clk; included by bare name
`ifndef MPPS_MAP_SVH
`define MPPS_MAP_SVH
`define MPPS_CLK_MHZ 20
`define MPPS_PERIOD_CYC 12'd240
`define MPPS_NOM_WIDTH 12'd60
`define MPPS_MIN_WIDTH 12'd2
`define MPPS_MAX_WIDTH 12'd200
`define MPPS_CUR_W 10
`define MPPS_TRIM_SHIFT 3
`define MPPS_SETUP_NS 1000
`define MPPS_SETUP_CYC ((`MPPS_SETUP_NS * `MPPS_CLK_MHZ + 999) / 1000)
`define MPPS_ZERO12 12'h000
`endif

// ### mpps_pkg.sv
// types for the multiphase pulse sequencer
// constants live in mpps_map.svh
package mpps_pkg;
    // channel count selection
    typedef enum logic [1:0] {MPPS_CH2, MPPS_CH3, MPPS_CH4} mpps_count_t;
    // captured operating mode
    typedef enum logic {MPPS_SERIAL, MPPS_PARALLEL} mpps_mode_t;
    // enable sequencing states
    typedef enum logic {MPPS_IDLE, MPPS_RUN} mpps_state_t;
    // four per-channel pulse outputs
    typedef struct packed {
        logic ch4;
        logic ch3;
        logic ch2;
        logic ch1;
    } mpps_pulse_t;
endpackage : mpps_pkg

// ### mpps_sequencer.sv
// multiphase pulse sequencer: phase interleave, balance trim, mode latch
// assumes pins arrive asynchronous; current samples are static words from sense adc
//
// Functional notes
// - detect channel count from upper sense pins
// - cycle is interval between pulse terminations; code fixes it at 240 clocks between pulse starts
// - four channels fire quarter cycle apart
// - fourth sense high gives three channels, thirds
// - third sense high gives two channels, halves
// - sample every active channel once per cycle
// - average sums active samples over active count
// - per-channel error filtered trims pulse width
// - each pulse rises at most once per interval
// - enable low disables regulators, tracks mode pin
// - mode captured at enable rising edge
// - low means serial, high means parallel
// - parallel mode keeps bridge regulator disabled
`timescale 1ns/1ps
`include "mpps_map.svh"
module mpps_sequencer (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pins from the board
    input wire logic enable_pin,
    input wire logic mode_select_pin,
    input wire logic third_channel_sense_neg,
    input wire logic fourth_channel_sense_neg,
    // sampled channel currents, same clock
    input wire logic [4*`MPPS_CUR_W-1:0] channel_current,
    // pulse outputs to drivers
    output logic channel_one_pulse,
    output logic channel_two_pulse,
    output logic channel_three_pulse,
    output logic channel_four_pulse,
    // regulator enables and status
    output logic core_reg_en,
    output logic bridge_reg_en,
    output logic parallel_code_mode,
    output logic serial_code_mode,
    output logic [1:0] active_count_code,
    output logic [`MPPS_CUR_W-1:0] cycle_mean_current
);
    localparam int CW = `MPPS_CUR_W;
    localparam logic [11:0] PER = `MPPS_PERIOD_CYC;

    // two-flop synchronisers for all pins
    logic [3:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
        end else begin
            pin_s1_reg <= {fourth_channel_sense_neg, third_channel_sense_neg,
                           mode_select_pin, enable_pin};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic en_s, sel_s, s3_s, s4_s;
    assign en_s = pin_s2_reg[0];
    assign sel_s = pin_s2_reg[1];
    assign s3_s = pin_s2_reg[2];
    assign s4_s = pin_s2_reg[3];

    // enable, mode latch and channel count state
    mpps_pkg::mpps_state_t state_reg, state_next;
    mpps_pkg::mpps_mode_t mode_reg, mode_next;
    mpps_pkg::mpps_count_t cnt_reg, cnt_next;
    logic core_en_reg, core_en_next, br_en_reg, br_en_next;
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        core_en_next = 1'b0;
        br_en_next = 1'b0;
        case (state_reg)
            mpps_pkg::MPPS_IDLE: begin
                // regulators off, mode pin tracked continuously
                mode_next = sel_s ? mpps_pkg::MPPS_PARALLEL : mpps_pkg::MPPS_SERIAL;
                // count from sense straps; third wins as it implies two
                if (s3_s) cnt_next = mpps_pkg::MPPS_CH2;
                else if (s4_s) cnt_next = mpps_pkg::MPPS_CH3;
                else cnt_next = mpps_pkg::MPPS_CH4;
                // tracked value at the edge is the latched one
                if (en_s) state_next = mpps_pkg::MPPS_RUN;
            end
            mpps_pkg::MPPS_RUN: begin
                // mode frozen until enable drops
                core_en_next = en_s;
                br_en_next = en_s && (mode_reg == mpps_pkg::MPPS_SERIAL);
                if (!en_s) state_next = mpps_pkg::MPPS_IDLE;
            end
            default: state_next = mpps_pkg::MPPS_IDLE;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= mpps_pkg::MPPS_IDLE;
            mode_reg <= mpps_pkg::MPPS_SERIAL;
            cnt_reg <= mpps_pkg::MPPS_CH4;
            core_en_reg <= 1'b0;
            br_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
            core_en_reg <= core_en_next;
            br_en_reg <= br_en_next;
        end
    end

    // cycle timer and per-channel interval start points
    logic [11:0] tmr_reg, tmr_next;
    logic [11:0] ofs [4];
    logic [3:0] act;
    always_comb begin
        tmr_next = (core_en_reg && tmr_reg != PER - 12'd1) ? tmr_reg + 12'd1 : `MPPS_ZERO12;
        // ofs is where each channel's interval starts; order 1-2-3-4
        act = 4'hf;
        ofs[0] = `MPPS_ZERO12;
        ofs[1] = PER / 12'd4;
        ofs[2] = PER / 12'd2;
        ofs[3] = (PER / 12'd4) * 12'd3;
        case (cnt_reg)
            mpps_pkg::MPPS_CH2: begin
                act = 4'h3;
                ofs[1] = PER / 12'd2;
            end
            mpps_pkg::MPPS_CH3: begin
                act = 4'h7;
                ofs[1] = PER / 12'd3;
                ofs[2] = (PER / 12'd3) * 12'd2;
            end
            default: act = 4'hf;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) tmr_reg <= `MPPS_ZERO12;
        else tmr_reg <= tmr_next;
    end

    // mean of active samples, taken once per cycle at timer wrap
    logic [CW+1:0] sum;
    logic [CW-1:0] mean_reg, mean_next;
    always_comb begin
        sum = '0;
        for (int i = 0; i < 4; i++)
            if (act[i]) sum = sum + {2'b00, channel_current[i*CW +: CW]};
        mean_next = mean_reg;
        if (tmr_reg == `MPPS_ZERO12 && core_en_reg) begin
            case (cnt_reg)
                mpps_pkg::MPPS_CH2: mean_next = sum[CW:1];
                mpps_pkg::MPPS_CH3: mean_next = CW'(sum / (CW+2)'(3));
                default: mean_next = sum[CW+1:2];
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) mean_reg <= '0;
        else mean_reg <= mean_next;
    end

    // per-channel filtered error, width and pulse with one-rise lockout
    logic [CW+1:0] filt_reg [4], filt_next [4];
    logic [11:0] wid [4];
    logic [3:0] pulse_reg, pulse_next, done_reg, done_next;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            logic [11:0] ph;
            logic signed [CW+1:0] err;
            logic signed [13:0] w;
            ph = (tmr_reg >= ofs[i]) ? tmr_reg - ofs[i] : tmr_reg + PER - ofs[i];
            // error is mean minus own sample, first-order filter
            err = $signed({2'b00, mean_reg}) - $signed({2'b00, channel_current[i*CW +: CW]});
            filt_next[i] = filt_reg[i];
            // timer parks at zero while disabled; without the enable gate
            // channel one would re-filter every clock and drift before a run
            if (ph == `MPPS_ZERO12 && act[i] && core_en_reg)
                filt_next[i] = (CW+2)'($signed(filt_reg[i])
                               + ((err - $signed(filt_reg[i])) >>> `MPPS_TRIM_SHIFT));
            // low-current channel gets wider pulse; clamp width
            w = $signed({2'b00, `MPPS_NOM_WIDTH}) + 14'($signed(filt_reg[i]));
            if (w < $signed({2'b00, `MPPS_MIN_WIDTH})) wid[i] = `MPPS_MIN_WIDTH;
            else if (w > $signed({2'b00, `MPPS_MAX_WIDTH})) wid[i] = `MPPS_MAX_WIDTH;
            else wid[i] = w[11:0];
            // interval restarts lockout; falling edge ends pulse
            done_next[i] = (ph == `MPPS_ZERO12) ? 1'b0 : done_reg[i];
            pulse_next[i] = 1'b0;
            if (core_en_reg && act[i] && ph < wid[i] && !done_next[i])
                pulse_next[i] = 1'b1;
            if (pulse_reg[i] && !pulse_next[i])
                done_next[i] = 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_reg <= 4'h0;
            done_reg <= 4'h0;
            for (int i = 0; i < 4; i++) filt_reg[i] <= '0;
        end else begin
            pulse_reg <= pulse_next;
            done_reg <= done_next;
            for (int i = 0; i < 4; i++) filt_reg[i] <= filt_next[i];
        end
    end

    // outputs straight from flops
    assign channel_one_pulse = pulse_reg[0];
    assign channel_two_pulse = pulse_reg[1];
    assign channel_three_pulse = pulse_reg[2];
    assign channel_four_pulse = pulse_reg[3];
    assign core_reg_en = core_en_reg;
    assign bridge_reg_en = br_en_reg;
    assign parallel_code_mode = (mode_reg == mpps_pkg::MPPS_PARALLEL);
    assign serial_code_mode = (mode_reg == mpps_pkg::MPPS_SERIAL);
    assign active_count_code = cnt_reg;
    assign cycle_mean_current = mean_reg;

    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    off_when_low_a: assert property (!en_s |=> ##1 !core_reg_en && !bridge_reg_en)
        else $error("regulators on with enable low");
    mode_frozen_a: assert property (state_reg == mpps_pkg::MPPS_RUN && en_s |=> $stable(mode_reg))
        else $error("mode changed while enabled");
    mode_capture_a: assert property ($rose(en_s) |=> parallel_code_mode == $past(sel_s))
        else $error("mode not captured at enable");
    serial_low_a: assert property (state_reg == mpps_pkg::MPPS_IDLE && !sel_s |=> serial_code_mode)
        else $error("low select not serial");
    bridge_off_a: assert property (parallel_code_mode |-> !bridge_reg_en)
        else $error("bridge on in parallel mode");
    one_rise_a: assert property ($rose(channel_one_pulse) |=> !$rose(channel_one_pulse) [*8])
        else $error("double rise");
    inactive_off_a: assert property (cnt_reg == mpps_pkg::MPPS_CH2 |-> ##1 !channel_three_pulse)
        else $error("inactive channel pulsed");
    count_four_a: assert property (state_reg == mpps_pkg::MPPS_IDLE && !s3_s && !s4_s
        |=> cnt_reg == mpps_pkg::MPPS_CH4) else $error("count not four");
    timer_wrap_a: assert property (tmr_reg == PER - 12'd1 |=> tmr_reg == `MPPS_ZERO12)
        else $error("cycle length wrong");
    run_c: cover property (core_reg_en && channel_four_pulse);
    two_c: cover property (cnt_reg == mpps_pkg::MPPS_CH2 && channel_two_pulse);
    three_c: cover property (cnt_reg == mpps_pkg::MPPS_CH3 && channel_three_pulse);
    par_c: cover property (parallel_code_mode && core_reg_en);
endmodule : mpps_sequencer

// ### mpps_driver_model.sv
// mosfet driver stand-in: logs each channel's pulse rises and widths
// assumes the pulse bundle is registered on core_clk rising edges
`timescale 1ns/1ps
module mpps_driver_model (
    // clock
    input wire logic core_clk,
    // pulse bundle, bit 0 is channel one
    input wire mpps_pkg::mpps_pulse_t gate
);
    int cyc = 0; // free cycle count
    int rise_at[4] = '{default: 0}; // cycle of last rise
    int width[4] = '{default: 0}; // length of last finished pulse
    int rises[4] = '{default: 0}; // rises seen so far
    logic [3:0] prev = 4'h0; // bundle one edge ago

    // sample on the edge, as a real gate driver would latch
    always @(posedge core_clk) begin
        cyc++;
        for (int i = 0; i < 4; i++) begin
            // rise edge: start of a pulse
            if (gate[i] && !prev[i]) begin
                rises[i]++;
                rise_at[i] = cyc;
            end
            // fall edge: pulse done
            if (!gate[i] && prev[i]) begin
                width[i] = cyc - rise_at[i];
            end
        end
        prev = gate;
    end
endmodule : mpps_driver_model

// ### multiphase_pwm_sequencer_tb.sv
// self-checking bench for the multiphase pulse sequencer
// assumes 50 ns core_clk; inputs change on falling edges only
`timescale 1ns/1ps
`include "mpps_map.svh"
module multiphase_pwm_sequencer_tb;
    logic core_clk, nrst, enable_pin, mode_select_pin; // clock, reset, pins
    logic third_channel_sense_neg, fourth_channel_sense_neg; // count straps
    logic [4*`MPPS_CUR_W-1:0] channel_current; // sense words
    logic ch1_p, ch2_p, ch3_p, ch4_p; // pulses
    logic core_reg_en, bridge_reg_en, parallel_code_mode, serial_code_mode;
    logic [1:0] active_count_code; // count status
    logic [`MPPS_CUR_W-1:0] cycle_mean_current; // mean status
    mpps_pkg::mpps_pulse_t gate; // bundle to the driver model
    int num_errors = 0; // mismatches
    int n_checks = 0; // comparisons

    assign gate = {ch4_p, ch3_p, ch2_p, ch1_p};

    mpps_sequencer u_dut (.core_clk(core_clk), .nrst(nrst), .enable_pin(enable_pin),
        .mode_select_pin(mode_select_pin), .third_channel_sense_neg(third_channel_sense_neg),
        .fourth_channel_sense_neg(fourth_channel_sense_neg), .channel_current(channel_current),
        .channel_one_pulse(ch1_p), .channel_two_pulse(ch2_p), .channel_three_pulse(ch3_p),
        .channel_four_pulse(ch4_p), .core_reg_en(core_reg_en), .bridge_reg_en(bridge_reg_en),
        .parallel_code_mode(parallel_code_mode), .serial_code_mode(serial_code_mode),
        .active_count_code(active_count_code), .cycle_mean_current(cycle_mean_current));

    mpps_driver_model u_drv (.core_clk(core_clk), .gate(gate));

    // clock: 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // compare and count
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // one enabled run: strap count and mode, then judge phases, mean and trim
    task automatic run_mode(input logic t3, input logic t4, input logic sel, input int n,
                            input logic [39:0] cur, input logic [9:0] mean);
        int base[4];
        int k;
        logic [9:0] s;
        @(negedge core_clk);
        third_channel_sense_neg = t3;
        fourth_channel_sense_neg = t4;
        mode_select_pin = sel;
        channel_current = cur;
        repeat (25) @(negedge core_clk); // mode held over 20 cycles first
        enable_pin = 1'b1;
        for (k = 0; k < 10 && core_reg_en !== 1'b1; k++) @(negedge core_clk);
        chk(12'(core_reg_en), 12'h001);
        chk(12'(parallel_code_mode), 12'(sel));
        chk(12'(serial_code_mode), 12'(!sel));
        chk(12'(bridge_reg_en), 12'(!sel));
        chk(12'(active_count_code), 12'(n - 2));
        repeat (720) @(negedge core_clk);
        mode_select_pin = !sel; // late flip must be ignored
        base = u_drv.rises;
        repeat (240) @(negedge core_clk);
        chk(12'(parallel_code_mode), 12'(sel));
        chk(12'(cycle_mean_current), 12'(mean));
        for (k = 0; k < 4; k++) begin
            chk(12'(u_drv.rises[k] - base[k]), 12'(k < n));
            if (k < n) begin
                s = cur[k*10 +: 10];
                chk(12'(((u_drv.rise_at[k] - u_drv.rise_at[0]) % 240 + 240) % 240),
                    12'(k * 240 / n));
                chk(12'((s < mean) ? (u_drv.width[k] > 60) : (u_drv.width[k] < 60)),
                    12'h001);
            end
        end
        enable_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        chk(12'(core_reg_en), 12'h000);
        chk(12'(bridge_reg_en), 12'h000);
    endtask : run_mode

    // watchdog: three runs need about 3000 cycles
    initial begin
        #400us;
        num_errors++;
        close_out();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        enable_pin = 1'b0;
        mode_select_pin = 1'b0;
        third_channel_sense_neg = 1'b0;
        fourth_channel_sense_neg = 1'b0;
        channel_current = 40'h0;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        chk(12'({core_reg_en, serial_code_mode, active_count_code}), 12'h006);
        chk(12'({ch4_p, ch3_p, ch2_p, ch1_p}), 12'h000);
        chk(12'(cycle_mean_current), 12'h000);
        // four channels, parallel mode, mean 250
        run_mode(1'b0, 1'b0, 1'b1, 4, {10'd400, 10'd300, 10'd200, 10'd100}, 10'd250);
        // three channels, serial mode, fourth word excluded
        run_mode(1'b0, 1'b1, 1'b0, 3, {10'd1000, 10'd150, 10'd110, 10'd100}, 10'd120);
        // two channels, third strap wins over fourth
        run_mode(1'b1, 1'b1, 1'b1, 2, {10'd900, 10'd900, 10'd300, 10'd100}, 10'd200);
        close_out();
    end
endmodule : multiphase_pwm_sequencer_tb
